// ===== core/osc_apb.sv
// APB slave holding the override control register and the status register.
// Assumes an APB3 master; every access completes with one wait-free access phase.
`timescale 1ns/100ps
module osc_apb
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    osc_if.regs regs
);
    logic setup;
    logic commit;
    logic hit;
    logic ovr_en_q;
    logic [CODE_W-1:0] ovr_code_q;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    assign setup = psel && !penable;
    assign commit = psel && penable && pready_q;
    assign hit = (paddr == CTRL_OFF) || (paddr == STAT_OFF);
    assign regs.ovr_en = ovr_en_q;
    assign regs.ovr_code = ovr_code_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Read word chosen from the address; unmapped space reads as zero.
    always_comb
    begin
        rd_word = '0;
        if (paddr == CTRL_OFF)
        begin
            rd_word[CTRL_OVR_BIT] = ovr_en_q;
            rd_word[CTRL_CODE_LSB +: CODE_W] = ovr_code_q;
        end
        else if (paddr == STAT_OFF)
        begin
            rd_word[STAT_CODE_LSB +: CODE_W] = regs.act_code;
            rd_word[STAT_FLOAT_BIT] = regs.float_bit;
            rd_word[STAT_DONE_BIT] = regs.start_done;
            rd_word[STAT_RUN_BIT] = regs.running;
            rd_word[STAT_LOG_LSB +: LOG_W] = regs.ratio_log;
        end
    end

    // Answer is registered in the setup cycle so every bus output comes from a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup && !hit;
            prdata_q <= (setup && !pwrite) ? rd_word : '0;
        end
    end

    // Only the control word is writable; status writes are dropped silently.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovr_en_q <= 1'b0;
            ovr_code_q <= '0;
        end
        else if (commit && pwrite && paddr == CTRL_OFF)
        begin
            ovr_en_q <= pwdata[CTRL_OVR_BIT];
            ovr_code_q <= pwdata[CTRL_CODE_LSB +: CODE_W];
        end
    end

endmodule : osc_apb

// ===== core/osc_filter.sv
// Divider-select code filter: a new code is taken only after it held still long enough.
// Assumes the raw code is synchronous to pclk.
`timescale 1ns/100ps
module osc_filter
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [CODE_W-1:0] raw_code,
    output logic [CODE_W-1:0] act_code,
    output logic code_stable
);
    logic [CODE_W-1:0] raw_q;
    logic [CODE_W-1:0] act_q;
    logic [CODE_W-1:0] diff;
    logic [FILT_W-1:0] dwell_q;
    logic [FILT_W-1:0] dwell_last;

    // Dwell length grows with the size of the jump, so a wandering level never wins.
    assign diff = (raw_q > act_q) ? (raw_q - act_q) : (act_q - raw_q);
    assign dwell_last = FILT_W'(FILT_STEP * (int'(diff) + FILT_BASE) * MASTER_CYC - 1); // [R10]
    assign act_code = act_q;
    assign code_stable = (raw_q == act_q) && (raw_code == raw_q); // [R19]

    // Previous raw sample, used to restart the dwell on any movement.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_q <= '0;
        else
            raw_q <= raw_code;
    end

    // Any change restarts the dwell, so codes passed on the way are never applied.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dwell_q <= '0;
            act_q <= '0;
        end
        else if (raw_code != raw_q || raw_q == act_q)
        begin
            dwell_q <= '0; // [R9]
        end
        else if (dwell_q == dwell_last)
        begin
            act_q <= raw_q; // [R9] [R10]
            dwell_q <= '0;
        end
        else
        begin
            dwell_q <= dwell_q + 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_code_settled: assert property ($changed(act_q) |-> act_q == $past(raw_code)) // [R9]
        else $error("Active code changed to a value that was not stable.");
    a_change_dwell: assert property ($changed(act_q) |-> $past(dwell_q) == $past(dwell_last)) // [R10]
        else $error("Active code changed before the full dwell.");

endmodule : osc_filter

// ===== core/osc_if.sv
// Interface between the register slave and the output control core.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
interface osc_if;
    import osc_pkg::*;
    logic ovr_en;
    logic [CODE_W-1:0] ovr_code;
    logic [CODE_W-1:0] act_code;
    logic float_bit;
    logic start_done;
    logic running;
    logic [LOG_W-1:0] ratio_log;

    modport regs (output ovr_en, output ovr_code, input act_code, input float_bit,
                  input start_done, input running, input ratio_log);
    modport core (input ovr_en, input ovr_code, output act_code, output float_bit,
                  output start_done, output running, output ratio_log);
endinterface : osc_if

// ===== core/osc_pkg.sv
// Shared constants, types and helpers for the divided oscillator output control.
// Assumes pclk is the master oscillator's time base at 100 MHz.
package osc_pkg;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int CLK_PERIOD_NS = 10;
    // One master period spans two clock cycles, so that ratio 1 still comes from a flop.
    localparam int T_MASTER_NS = 20;
    localparam int MASTER_CYC = T_MASTER_NS / CLK_PERIOD_NS;
    localparam int START_MASTER = 500;
    localparam int START_CYC = START_MASTER * MASTER_CYC;
    localparam int START_W = 11;
    localparam logic [START_W-1:0] START_LAST = START_W'(START_CYC - 1);
    localparam int FILT_STEP = 16;
    localparam int FILT_BASE = 6;
    localparam int FILT_W = 10;

    // ==========================================================================
    // Divider and code layout
    // ==========================================================================
    localparam int CODE_W = 4;
    localparam int LOG_W = 3;
    localparam int CNT_W = 8;
    localparam int FLOAT_BIT = 3;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CODE_W-1:0] CODE_TOP = 4'hf;
    localparam logic [LOG_W-1:0] LOG_HALF_MAX = 3'h1;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFF = 12'h004;
    localparam int CTRL_OVR_BIT = 0;
    localparam int CTRL_CODE_LSB = 4;
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_FLOAT_BIT = 4;
    localparam int STAT_DONE_BIT = 5;
    localparam int STAT_RUN_BIT = 6;
    localparam int STAT_LOG_LSB = 8;

    typedef enum logic [1:0] {OSC_ST_START, OSC_ST_IDLE, OSC_ST_RUN} osc_state_t;

    // Log2 of the division ratio: low half counts up, high half mirrors it.
    function automatic logic [LOG_W-1:0] osc_log_of(input logic [CODE_W-1:0] code);
        if (code[FLOAT_BIT])
        begin
            osc_log_of = LOG_W'(CODE_TOP - code);
        end
        else
        begin
            osc_log_of = code[LOG_W-1:0];
        end
    endfunction : osc_log_of

    // Counter preset so the low phase before the first rise is one master period,
    // or half an output period when the ratio is below four.
    function automatic logic [CNT_W-1:0] osc_load(input logic [LOG_W-1:0] lg);
        if (lg <= LOG_HALF_MAX)
        begin
            osc_load = CNT_ZERO;
        end
        else
        begin
            osc_load = (CNT_ONE << lg) - CNT_W'(MASTER_CYC);
        end
    endfunction : osc_load

endpackage : osc_pkg

// ===== core/osc_top.sv
// Divided oscillator output control: divider, enable sync, code filter, start-up.
// Assumes pclk is the master time base and all pin inputs are synchronous to it.
//
// How it works
// R1: Enable high drives the divided clock actively, regardless of the float bit.
// R2: Enable low with float bit set leaves the output undriven.
// R3: Enable low with float bit clear drives the output low.
// R4: Rising enable waits for oscillator alignment so the first pulse is full width.
// R5: Ratio 1 or 2: enable delay is at most one output period.
// R6: Ratio above 2: enable delay is at most two master periods.
// R7: Falling enable disables the output at once, cutting any high pulse.
// R8: In float mode enabling usually drives low first; first high pulse stays full.
// R9: Code keeps being sampled; only a stable code applies, never intermediate ones.
// R10: Code change latency is sixteen times difference plus six master periods.
// R11: A confirmed code switches the ratio without glitches.
// R12: Reset starts start-up; output stays undriven throughout.
// R13: Start-up lasts 500 master periods whatever the ratio.
// R14: Enabled at start-up end: low one master or half output period first.
// R15: Disabled at start-up end: driven low if float clear, else stays undriven.
// R16: One code sets both float bit and division ratio.
// R17: The code is four bits from a converter sampling the ratio pin level.
// R18: Codes 0-7 float 0, ratio 2^code; 8-15 float 1, ratio 2^(15-code).
// R19: Start-up waits for a stable valid code and lengthens while it moves.
// R20: A binary counter on the master clock gives a square wave at master/ratio.
`timescale 1ns/100ps
module osc_top
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic out_enable,
    input wire logic [CODE_W-1:0] divider_select_code,
    output logic osc_out,
    output logic osc_out_oe
);

    // ==========================================================================
    // Declarations
    // ==========================================================================
    osc_if u_if ();

    osc_state_t st_q;
    osc_state_t st_d;
    logic [CODE_W-1:0] raw_code;
    logic [CODE_W-1:0] act_code;
    logic code_stable;
    logic float_when_disabled;
    logic [LOG_W-1:0] log_new;
    logic [LOG_W-1:0] log_q;
    logic [LOG_W-1:0] log_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [START_W-1:0] start_cnt_q;
    logic start_done;
    logic load;
    logic out_q;
    logic out_d;
    logic out_oe_q;
    logic out_oe_d;

    // ==========================================================================
    // Register slave
    // ==========================================================================
    osc_apb u_apb (
        .pclk (pclk),
        .presetn (presetn),
        .paddr (paddr),
        .psel (psel),
        .penable (penable),
        .pwrite (pwrite),
        .pwdata (pwdata),
        .prdata (prdata),
        .pready (pready),
        .pslverr (pslverr),
        .regs (u_if.regs)
    );

    // ==========================================================================
    // Code selection and filtering
    // ==========================================================================
    // Software may substitute its own code; it goes through the same filter as the pin.
    assign raw_code = u_if.ovr_en ? u_if.ovr_code : divider_select_code; // [R17]

    osc_filter u_filter (
        .pclk (pclk),
        .presetn (presetn),
        .raw_code (raw_code),
        .act_code (act_code),
        .code_stable (code_stable)
    );

    // Both the float bit and the ratio come from the one filtered code.
    assign float_when_disabled = act_code[FLOAT_BIT]; // [R16] [R18]
    assign log_new = osc_log_of(act_code); // [R16] [R18]

    // Status back to the register slave.
    assign u_if.act_code = act_code;
    assign u_if.float_bit = float_when_disabled;
    assign u_if.start_done = (st_q != OSC_ST_START);
    assign u_if.running = (st_q == OSC_ST_RUN);
    assign u_if.ratio_log = log_q;

    // ==========================================================================
    // Start-up interval
    // ==========================================================================
    // Counter saturates; start-up also waits on a settled code, so a moving level
    // lengthens it without bound, which is the intended trade.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_cnt_q <= '0;
        else if (st_q == OSC_ST_START && start_cnt_q != START_LAST)
            start_cnt_q <= start_cnt_q + 1'b1; // [R13]
    end

    assign start_done = (start_cnt_q == START_LAST) && code_stable; // [R13] [R19]

    // ==========================================================================
    // Output state machine
    // ==========================================================================
    // Next state; a falling enable leaves the run state with no alignment wait.
    always_comb
    begin
        st_d = st_q;
        load = 1'b0;
        case (st_q)
            OSC_ST_START:
            begin
                if (start_done && out_enable)
                begin
                    st_d = OSC_ST_RUN; // [R14]
                    load = 1'b1;
                end
                else if (start_done)
                begin
                    st_d = OSC_ST_IDLE; // [R15]
                end
            end
            OSC_ST_IDLE:
            begin
                if (out_enable)
                begin
                    st_d = OSC_ST_RUN; // [R4]
                    load = 1'b1;
                end
            end
            OSC_ST_RUN:
            begin
                if (!out_enable)
                    st_d = OSC_ST_IDLE; // [R7]
            end
            default:
            begin
                st_d = OSC_ST_START;
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= OSC_ST_START; // [R12]
        else
            st_q <= st_d;
    end

    // ==========================================================================
    // Divider
    // ==========================================================================
    // On enable the counter is preset so the output first sits low for one master
    // period, or half an output period at ratios below four, then rises on time.
    // Apart from the enable preset, a new ratio is taken only at the counter wrap, where every tap is at the
    // start of a low phase, so neither pulse is shortened.
    always_comb
    begin
        if (load)
        begin
            log_d = log_new;
            cnt_d = osc_load(log_new); // [R4] [R5] [R6] [R14]
        end
        else if (cnt_q == CNT_MAX)
        begin
            log_d = log_new; // [R11]
            cnt_d = CNT_ZERO;
        end
        else
        begin
            log_d = log_q;
            cnt_d = cnt_q + CNT_ONE; // [R20]
        end
    end

    // Counter and ratio registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= CNT_ZERO;
            log_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            log_q <= log_d;
        end
    end

    // ==========================================================================
    // Pin drive
    // ==========================================================================
    // Computed from the next state so that enable and disable both take one cycle.
    always_comb
    begin
        out_oe_d = (st_d == OSC_ST_RUN) ||
                   (st_d == OSC_ST_IDLE && !float_when_disabled); // [R1] [R2] [R3] [R15]
        out_d = (st_d == OSC_ST_RUN) && cnt_d[log_d]; // [R1] [R7] [R8] [R20]
    end

    // Output flops; the enable flop is what a board-level wired-OR relies on.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q <= 1'b0;
            out_oe_q <= 1'b0; // [R12]
        end
        else
        begin
            out_q <= out_d;
            out_oe_q <= out_oe_d;
        end
    end

    assign osc_out = out_q;
    assign osc_out_oe = out_oe_q;

    // ==========================================================================
    // Checks
    // ==========================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_enable_from_idle;
        st_q == OSC_ST_IDLE && out_enable;
    endsequence

    sequence s_enable_held;
        s_enable_from_idle ##1 out_enable [*2];
    endsequence

    sequence s_startup_enabled;
        st_q == OSC_ST_START && start_done && out_enable;
    endsequence

    a_run_drives: assert property ((st_q == OSC_ST_RUN && out_enable) |=> osc_out_oe) // [R1]
        else $error("Output not driven while enabled.");

    a_float_off: assert property ((st_q != OSC_ST_START && !out_enable && float_when_disabled)
        |=> !osc_out_oe) // [R2] [R15]
        else $error("Output driven while disabled in float mode.");

    a_hold_low: assert property ((st_q != OSC_ST_START && !out_enable && !float_when_disabled)
        |=> osc_out_oe && !osc_out) // [R3] [R15]
        else $error("Output not held low while disabled.");

    a_low_first: assert property (s_enable_from_idle |=> osc_out_oe && !osc_out) // [R4] [R8]
        else $error("Enabled output did not start low.");

    a_enable_delay: assert property (s_enable_held |=> osc_out || $past(osc_out)) // [R5] [R6]
        else $error("First rising edge came too late after enable.");

    a_cut_short: assert property ((st_q == OSC_ST_RUN && !out_enable) |=> !osc_out) // [R7]
        else $error("High pulse not cut when enable fell.");

    a_ratio_switch: assert property ($changed(log_q) |-> $past(cnt_q) == CNT_MAX ||
        $past(load)) // [R11]
        else $error("Ratio changed away from a clean boundary.");

    a_startup_float: assert property (st_q == OSC_ST_START |-> !osc_out_oe) // [R12]
        else $error("Output driven during start-up.");

    a_startup_len: assert property (st_q != OSC_ST_START |-> start_cnt_q == START_LAST) // [R13]
        else $error("Start-up ended early.");

    a_startup_low: assert property (s_startup_enabled |=> osc_out_oe && !osc_out) // [R14]
        else $error("Output did not go low before first edge after start-up.");

    a_code_map: assert property ($changed(log_q) |-> log_q == osc_log_of($past(act_code))) // [R18]
        else $error("Ratio does not match the active code.");

endmodule : osc_top

// ===== sim/osc_load.sv
// Board load model hanging on the oscillator output pin.
// Assumes a pull-up on the board, so an undriven pin reads high.
`timescale 1ns/100ps
module osc_load
(
    input wire logic osc_out,
    input wire logic osc_out_oe,
    output logic pin_level
);
    // ========================================================================
    // Pin resolution
    // ========================================================================
    // The pull-up wins only while the driver is off, so a float never reads as a low.
    assign pin_level = osc_out_oe ? osc_out : 1'b1;
endmodule : osc_load

// ===== sim/tb_divided_oscillator_output_control.sv
// Self-checking bench for the divided oscillator output control.
// Assumes osc_pkg, osc_top and osc_load are compiled before it.
`timescale 1ns/100ps
module tb_divided_oscillator_output_control;
    import osc_pkg::*;
    logic pclk;
    logic presetn;
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic out_enable;
    logic [CODE_W-1:0] divider_select_code;
    logic osc_out;
    logic osc_out_oe;
    logic pin_level;
    logic [DATA_W-1:0] rd;
    logic err;
    int mismatches;
    int comparisons;
    int c;

    osc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .out_enable(out_enable),
        .divider_select_code(divider_select_code), .osc_out(osc_out), .osc_out_oe(osc_out_oe));
    osc_load LOAD (.osc_out(osc_out), .osc_out_oe(osc_out_oe), .pin_level(pin_level));

    // ========================================================================
    // Clock and helpers
    // ========================================================================
    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // One APB transfer; the request is held until pready is sampled high.
    // The answer is read while it stands, just after the edge that raises pready.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        #1;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Enables the output and measures delay, the low lead-in and one full period.
    task automatic run_pulse(input int ratio, input int dly);
        int n;
        @(posedge pclk);
        out_enable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
            if (n == 1)
            begin
                check("lead_in", {30'h0, osc_out_oe, pin_level}, 32'h2);
            end
        end
        while (osc_out !== 1'b1 && n < 300);
        check("enable_delay", 32'(n), 32'(dly));
        n = 0;
        while (osc_out === 1'b1 && n < 300)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("high_len", 32'(n), 32'(ratio));
        n = 0;
        while (osc_out === 1'b0 && n < 300)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("low_len", 32'(n), 32'(ratio));
    endtask : run_pulse

    // Drops enable mid high pulse; the pulse must be cut at once.
    task automatic cut(input logic fl);
        @(posedge pclk);
        out_enable <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check("cut_out", {31'h0, osc_out}, 32'h0);
        check("cut_oe", {31'h0, osc_out_oe}, {31'h0, !fl});
        check("cut_pin", {31'h0, pin_level}, {31'h0, fl});
    endtask : cut

    // ========================================================================
    // Tests
    // ========================================================================
    // Start-up, register access, enable timing, code changes from the low half into the high half and within the high half.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        out_enable = 1'b0;
        divider_select_code = 4'h3;
        mismatches = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (990) @(posedge pclk);
        #1;
        check("start_float", {30'h0, osc_out_oe, pin_level}, 32'h1);
        c = 990;
        while (osc_out_oe !== 1'b1 && c < 1100)
        begin
            @(posedge pclk);
            #1;
            c++;
        end
        check("start_len", 32'(c >= 1000 && c <= 1003), 32'h1);
        check("start_low", {31'h0, osc_out}, 32'h0);
        $display("test startup done");
        apb(1'b0, STAT_OFF, 32'h0);
        check("status", rd & 32'h7ff, 32'h323);
        apb(1'b1, STAT_OFF, 32'hffffffff);
        apb(1'b0, STAT_OFF, 32'h0);
        check("status_ro", rd & 32'h7ff, 32'h323);
        apb(1'b0, CTRL_OFF, 32'h0);
        check("ctrl_reset", rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        $display("test registers done");
        run_pulse(8, 3);
        cut(1'b0);
        $display("test ratio 8 done");
        @(posedge pclk);
        divider_select_code <= 4'hc;
        repeat (465) @(posedge pclk);
        apb(1'b0, STAT_OFF, 32'h0);
        check("code_held", rd & 32'h7ff, 32'h323);
        repeat (20) @(posedge pclk);
        apb(1'b0, STAT_OFF, 32'h0);
        check("code_new", rd & 32'h7ff, 32'h33c);
        #1;
        check("float_idle", {30'h0, osc_out_oe, pin_level}, 32'h1);
        run_pulse(8, 3);
        cut(1'b1);
        $display("test float mode done");
        @(posedge pclk);
        divider_select_code <= 4'hf;
        repeat (300) @(posedge pclk);
        run_pulse(1, 2);
        cut(1'b1);
        $display("test ratio 1 done");
        apb(1'b1, CTRL_OFF, 32'h000000f1);
        apb(1'b0, CTRL_OFF, 32'h0);
        check("ctrl_rw", rd, 32'hf1);
        // Mid-run reset with enable already high: start-up must end in a low lead-in.
        @(posedge pclk);
        presetn <= 1'b0;
        out_enable <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        c = 0;
        while (osc_out_oe !== 1'b1 && c < 1100)
        begin
            @(posedge pclk);
            #1;
            c++;
        end
        check("restart_len", 32'(c >= 1000 && c <= 1003), 32'h1);
        check("restart_low", {31'h0, osc_out}, 32'h0);
        @(posedge pclk);
        #1;
        check("restart_rise", {31'h0, osc_out}, 32'h1);
        $display("test restart done");
        test_done();
    end

    // Cuts a hang short well past the expected run of about 3000 cycles.
    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        $display("[ERR] watchdog expected end seen hang");
        test_done();
    end
endmodule : tb_divided_oscillator_output_control
